// *** design/sls_pkg.sv ***
// Package of constants and types for the status lamp sequencer
package sls_pkg;
  // Lamp test time and derived cycle count at 25 MHz
  localparam int LAMP_TEST_MS = 1000;
  localparam int CLK_KHZ = 25000;
  localparam int LAMP_TEST_CYC = LAMP_TEST_MS * CLK_KHZ;
  // Default blink half period in milliseconds, and code pause in blink half periods
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int CODE_PAUSE_HALVES = 6;
  // Fault codes
  localparam logic [3:0] CODE_NVM = 4'h3;
  localparam logic [3:0] CODE_SERIAL = 4'h4;
  localparam logic [3:0] CODE_APP = 4'h6;
  localparam logic [3:0] CODE_CAL = 4'h6;
  localparam logic [3:0] CODE_WDOG = 4'h7;
  localparam logic [3:0] CODE_NONE = 4'h0;
  // Display states
  typedef enum logic [2:0] {
    SLS_TEST = 3'b000,
    SLS_IDLE = 3'b001,
    SLS_RUN = 3'b010,
    SLS_LOST = 3'b011,
    SLS_UPDATE = 3'b100,
    SLS_FAULT = 3'b101,
    SLS_ABNORMAL = 3'b110,
    SLS_BADTEST = 3'b111
  } sls_state_type;
endpackage

// *** design/sls_top.sv ***
// Status lamp sequencer: health and calibration lamp patterns
// Operation
// - After reset health lamp red one second, then blinking green if self-test passed.
// - During power-on test health lamp solid red, calibration lamp solid green.
// - Idle or unconnected: health lamp blinks green, calibration lamp off.
// - Run mode: health lamp solid green, calibration lamp off.
// - Connection lost: health lamp blinks red, calibration lamp off.
// - Firmware update: health lamp blinks red, calibration lamp solid green.
// - Bad configuration memory checksum shows code 3.
// - All-zero serial number shows code 4, only with factory jumper fitted.
// - Bad application checksum shows code 6.
// - Unreadable calibration data shows code 6; data passes uncalibrated.
// - Watchdog expiry shows code 7.
// - Lamp requests come from both hardware interface logic and firmware.
`timescale 1ns/100ps
module sls_top #(
  parameter int TEST_CYC = sls_pkg::LAMP_TEST_CYC,
  parameter int HALF_CYC = sls_pkg::BLINK_HALF_CYC,
  parameter int PAUSE_HALVES = sls_pkg::CODE_PAUSE_HALVES,
  parameter bit FAULT_OVER_UPDATE = 1'b1
) (
  input wire logic CORE_CLK_I, // 25 MHz clock
  input wire logic RST_I, // Async reset, active high
  input wire logic CE_I, // Clock enable
  input wire logic SELFTEST_OK_I, // Self-test passed
  input wire logic CONNECTED_I, // Controller connection up
  input wire logic RUN_MODE_I, // Controller in run mode
  input wire logic CONN_LOST_I, // Controller link lost
  input wire logic FW_UPDATE_I, // Firmware update active
  input wire logic NVM_CRC_BAD_I, // Interface chip memory checksum bad
  input wire logic SERIAL_ZERO_I, // Serial number all zeros
  input wire logic FACTORY_TEST_JUMPER_I, // Factory jumper fitted
  input wire logic APP_CRC_BAD_I, // Application checksum bad
  input wire logic CAL_BAD_I, // Calibration data unreadable
  input wire logic WDOG_EXPIRED_I, // Watchdog timed out
  input wire logic HW_FAIL_I, // Uncoded hardware failure
  input wire logic ABNORMAL_I, // Abnormal hardware state
  output logic HEALTH_RED_O, // Health lamp red
  output logic HEALTH_GREEN_O, // Health lamp green
  output logic CAL_GREEN_O, // Calibration lamp green
  output logic CAL_BYPASS_O // Pass data without calibration
);

  // ------------------------------------------------
  // Fault code selection
  // ------------------------------------------------
  // Highest code wins; watchdog means firmware is dead so it dominates
  function automatic logic [3:0] pick_code(input logic [5:0] f);
    logic [3:0] c;
    c = sls_pkg::CODE_NONE;
    if (f[0])
      c = sls_pkg::CODE_WDOG;
    else if (f[1] || f[2])
      c = f[1] ? sls_pkg::CODE_APP : sls_pkg::CODE_CAL;
    else if (f[3] && f[4])
      c = sls_pkg::CODE_SERIAL;
    else if (f[5])
      c = sls_pkg::CODE_NVM;
    return c;
  endfunction

  logic [3:0] code;
  assign code = pick_code({NVM_CRC_BAD_I, FACTORY_TEST_JUMPER_I, SERIAL_ZERO_I,
                           CAL_BAD_I, APP_CRC_BAD_I, WDOG_EXPIRED_I});

  // ------------------------------------------------
  // State, timers and code sequencer
  // ------------------------------------------------
  sls_pkg::sls_state_type state, next_state;
  logic [31:0] tmr, next_tmr;
  logic [31:0] half, next_half;
  logic phase, next_phase;
  logic [4:0] step, next_step;
  logic cal_blink, next_cal_blink;
  logic next_hr, next_hg, next_cg, next_byp;

  // Next state: test window first, then priority among requests
  always_comb
  begin
    next_state = state;
    next_tmr = tmr;
    if (state == sls_pkg::SLS_TEST || state == sls_pkg::SLS_BADTEST)
    begin
      if (tmr < 32'(TEST_CYC - 1))
        next_tmr = tmr + 32'h0000_0001;
      else if (!SELFTEST_OK_I || state == sls_pkg::SLS_BADTEST)
        next_state = sls_pkg::SLS_BADTEST; // Failed test latches until reset
      else
        next_state = sls_pkg::SLS_IDLE;
    end
    else if (ABNORMAL_I)
      next_state = sls_pkg::SLS_ABNORMAL;
    else if ((code != sls_pkg::CODE_NONE || HW_FAIL_I) &&
             (FAULT_OVER_UPDATE || !FW_UPDATE_I))
      next_state = sls_pkg::SLS_FAULT;
    else if (FW_UPDATE_I)
      next_state = sls_pkg::SLS_UPDATE;
    else if (CONN_LOST_I)
      next_state = sls_pkg::SLS_LOST;
    else if (CONNECTED_I && RUN_MODE_I)
      next_state = sls_pkg::SLS_RUN;
    else
      next_state = sls_pkg::SLS_IDLE;
  end

  // Blink phase and code groups; a group is code flashes then a pause
  always_comb
  begin
    next_half = half;
    next_phase = phase;
    next_step = step;
    next_cal_blink = 1'b0;
    if (half >= 32'(HALF_CYC - 1))
    begin
      next_half = 32'h0000_0000;
      next_phase = ~phase;
      if (step >= 5'(2 * code + PAUSE_HALVES - 1))
        next_step = 5'h00;
      else
        next_step = step + 5'h01;
    end
    else
      next_half = half + 32'h0000_0001;
    if (code == sls_pkg::CODE_NONE)
      next_step = 5'h00;
    next_cal_blink = (next_step < 5'(2 * code)) && !next_step[0];
  end

  // Lamp decode from state
  always_comb
  begin
    next_hr = 1'b0;
    next_hg = 1'b0;
    next_cg = 1'b0;
    next_byp = CAL_BAD_I;
    case (next_state)
      sls_pkg::SLS_TEST:
      begin
        next_hr = 1'b1;
        next_cg = 1'b1;
      end
      sls_pkg::SLS_BADTEST: next_hr = 1'b1;
      sls_pkg::SLS_IDLE: next_hg = next_phase;
      sls_pkg::SLS_RUN: next_hg = 1'b1;
      sls_pkg::SLS_LOST: next_hr = next_phase;
      sls_pkg::SLS_UPDATE:
      begin
        next_hr = next_phase;
        next_cg = 1'b1;
      end
      sls_pkg::SLS_FAULT:
      begin
        next_hr = 1'b1;
        next_cg = next_cal_blink;
      end
      default:
      begin
        next_hr = 1'b0;
      end
    endcase
  end

  // Registers; outputs come straight from these flops
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state <= sls_pkg::SLS_TEST;
      tmr <= 32'h0000_0000;
      half <= 32'h0000_0000;
      phase <= 1'b0;
      step <= 5'h00;
      cal_blink <= 1'b0;
      HEALTH_RED_O <= 1'b1;
      HEALTH_GREEN_O <= 1'b0;
      CAL_GREEN_O <= 1'b1;
      CAL_BYPASS_O <= 1'b0;
    end
    else if (CE_I)
    begin
      state <= next_state;
      tmr <= next_tmr;
      half <= next_half;
      phase <= next_phase;
      step <= next_step;
      cal_blink <= next_cal_blink;
      HEALTH_RED_O <= next_hr;
      HEALTH_GREEN_O <= next_hg;
      CAL_GREEN_O <= next_cg;
      CAL_BYPASS_O <= next_byp;
    end
  end

  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  sequence s_in_test;
    state == sls_pkg::SLS_TEST;
  endsequence

  a_test_lamps: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    s_in_test |-> HEALTH_RED_O && CAL_GREEN_O && !HEALTH_GREEN_O)
    else $error("lamp test pattern wrong");
  a_test_exit: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (CE_I && tmr == 32'(TEST_CYC - 1) && SELFTEST_OK_I) and s_in_test
    |=> state == sls_pkg::SLS_IDLE)
    else $error("test window did not end");
  a_test_hold: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (tmr < 32'(TEST_CYC - 1)) and s_in_test |=> state == sls_pkg::SLS_TEST)
    else $error("test window left early");
  a_badtest_hold: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    state == sls_pkg::SLS_BADTEST |=> state == sls_pkg::SLS_BADTEST && HEALTH_RED_O
    && !CAL_GREEN_O)
    else $error("failed self-test not held");
  a_run_green: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    state == sls_pkg::SLS_RUN |-> HEALTH_GREEN_O && !HEALTH_RED_O && !CAL_GREEN_O)
    else $error("run lamps wrong");
  a_idle_blink: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    state == sls_pkg::SLS_IDLE |-> HEALTH_GREEN_O == phase && !CAL_GREEN_O)
    else $error("idle blink wrong");
  a_lost_blink: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    state == sls_pkg::SLS_LOST |-> HEALTH_RED_O == phase && !CAL_GREEN_O)
    else $error("lost blink wrong");
  a_update_lamps: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    state == sls_pkg::SLS_UPDATE |-> CAL_GREEN_O && HEALTH_RED_O == phase)
    else $error("update lamps wrong");
  a_fault_red: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    state == sls_pkg::SLS_FAULT |-> HEALTH_RED_O && !HEALTH_GREEN_O
    && CAL_GREEN_O == cal_blink)
    else $error("fault lamps wrong");
  a_wdog_code: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    WDOG_EXPIRED_I |-> code == sls_pkg::CODE_WDOG)
    else $error("watchdog code wrong");
  a_serial_gate: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    SERIAL_ZERO_I && !FACTORY_TEST_JUMPER_I |-> code != sls_pkg::CODE_SERIAL)
    else $error("serial code without jumper");
  a_abnormal_off: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    state == sls_pkg::SLS_ABNORMAL |-> !HEALTH_RED_O && !HEALTH_GREEN_O && !CAL_GREEN_O)
    else $error("abnormal lamps not off");
endmodule

// *** tb/sls_lamp_model.sv ***
// Lamp model: counts lit cycles of each lamp and calibration lamp flashes
`timescale 1ns/100ps
module sls_lamp_model (
  input wire logic clk_i, // Sampling clock
  input wire logic clr_i, // Clear all counts
  input wire logic red_i, // Health lamp red drive
  input wire logic green_i, // Health lamp green drive
  input wire logic cal_i, // Calibration lamp drive
  output logic [7:0] red_cnt_o, // Cycles red lit
  output logic [7:0] green_cnt_o, // Cycles green lit
  output logic [7:0] cal_cnt_o, // Cycles calibration lit
  output logic [7:0] flash_cnt_o // Calibration flashes seen
);
  logic cal_prev;
  // ----------------------------------------
  // Counters
  // ----------------------------------------
  // Unknown drive counts as dark, so an X lamp never looks lit
  always_ff @(posedge clk_i)
  begin
    cal_prev <= (cal_i === 1'b1);
    if (clr_i)
    begin
      red_cnt_o <= 8'h00;
      green_cnt_o <= 8'h00;
      cal_cnt_o <= 8'h00;
      flash_cnt_o <= 8'h00;
    end
    else
    begin
      red_cnt_o <= red_cnt_o + 8'((red_i === 1'b1));
      green_cnt_o <= green_cnt_o + 8'((green_i === 1'b1));
      cal_cnt_o <= cal_cnt_o + 8'((cal_i === 1'b1));
      flash_cnt_o <= flash_cnt_o + 8'((cal_i === 1'b1) && !cal_prev);
    end
  end
endmodule

// *** tb/test_sls_top.sv ***
// Testbench for the status lamp sequencer
`timescale 1ns/100ps
module test_sls_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  logic [13:0] stim = 14'h0003;
  logic red, green, cal, bypass;
  logic [7:0] red_cnt, green_cnt, cal_cnt, flash;
  int mismatches = 0;
  int num_checks = 0;
  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  // Short counts keep the run brief: test 20, half period 4
  initial forever #20 clk = ~clk;
  sls_top #(.TEST_CYC(20), .HALF_CYC(4), .PAUSE_HALVES(6), .FAULT_OVER_UPDATE(1'b1)) u_sls_top (
    .CORE_CLK_I(clk), .RST_I(rst), .CE_I(stim[0]), .SELFTEST_OK_I(stim[1]),
    .CONNECTED_I(stim[2]), .RUN_MODE_I(stim[3]), .CONN_LOST_I(stim[4]),
    .FW_UPDATE_I(stim[5]), .NVM_CRC_BAD_I(stim[6]), .SERIAL_ZERO_I(stim[7]),
    .FACTORY_TEST_JUMPER_I(stim[8]), .APP_CRC_BAD_I(stim[9]), .CAL_BAD_I(stim[10]),
    .WDOG_EXPIRED_I(stim[11]), .HW_FAIL_I(stim[12]), .ABNORMAL_I(stim[13]),
    .HEALTH_RED_O(red), .HEALTH_GREEN_O(green), .CAL_GREEN_O(cal), .CAL_BYPASS_O(bypass));
  sls_lamp_model u_sls_lamp_model (.clk_i(clk), .clr_i(clr), .red_i(red), .green_i(green),
    .cal_i(cal), .red_cnt_o(red_cnt), .green_cnt_o(green_cnt), .cal_cnt_o(cal_cnt),
    .flash_cnt_o(flash));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task check(logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %0d expected %0d", $time, seen, exp);
    end
  endtask
  // Lamp class: 0 off, 1 solid, 2 blinking
  function logic [7:0] cls(logic [7:0] c, int n);
    return (c == 8'h00) ? 8'h00 : ((c == 8'(n)) ? 8'h01 : 8'h02);
  endfunction
  task measure(int n);
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  // Settle long enough for a full code group, then watch n cycles
  task apply(logic [13:0] v, int n);
    @(negedge clk) stim = v;
    repeat (90) @(negedge clk);
    measure(n);
  endtask
  task pat(logic [13:0] v, logic [7:0] r, logic [7:0] g, logic [7:0] c);
    apply(v, 40);
    check(cls(red_cnt, 40), r);
    check(cls(green_cnt, 40), g);
    check(cls(cal_cnt, 40), c);
  endtask
  task reset_dut();
    rst = 1'b1;
    repeat (16) @(negedge clk);
    check({4'h0, red, green, cal, bypass}, 8'h0A);
    rst = 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_lamp_test();
    reset_dut();
    measure(12);
    check({red_cnt == 8'd12, green_cnt == 8'd0, cal_cnt == 8'd12}, 8'h07);
  endtask
  task t_states();
    pat(14'h0003, 8'h00, 8'h02, 8'h00);
    pat(14'h0007, 8'h00, 8'h02, 8'h00);
    pat(14'h000F, 8'h00, 8'h01, 8'h00);
    pat(14'h0013, 8'h02, 8'h00, 8'h00);
    pat(14'h0023, 8'h02, 8'h00, 8'h01);
    pat(14'h1023, 8'h01, 8'h00, 8'h00);
    pat(14'h2043, 8'h00, 8'h00, 8'h00);
    pat(14'h0083, 8'h00, 8'h02, 8'h00);
  endtask
  task t_codes();
    logic [13:0] v [6];
    int k [6];
    int n;
    // Last entry has two faults at once: the watchdog code must win
    v = '{14'h0043, 14'h0183, 14'h0203, 14'h0403, 14'h0803, 14'h0843};
    k = '{3, 4, 6, 6, 7, 7};
    for (int i = 0; i < 6; i++)
    begin
      n = (2 * k[i] + 6) * 4;
      apply(v[i], n);
      check(flash, 8'(k[i]));
      check(red_cnt, 8'(n));
      check({7'h00, bypass}, {7'h00, i == 3});
    end
  endtask
  task t_failed_selftest();
    stim = 14'h0001;
    reset_dut();
    pat(14'h0001, 8'h01, 8'h00, 8'h00);
    pat(14'h0003, 8'h01, 8'h00, 8'h00);
  endtask
  // Clock enable low holds the lamp test well past its window
  task t_freeze();
    stim = 14'h0002;
    reset_dut();
    pat(14'h0002, 8'h01, 8'h00, 8'h01);
    pat(14'h0003, 8'h00, 8'h02, 8'h00);
  endtask
  task stop_test();
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    t_lamp_test();
    t_states();
    t_codes();
    t_failed_selftest();
    t_freeze();
    stop_test();
  end
endmodule
